// [src/async_mem_sequencer.sv]
// Function
// - Phases timed in units of one or two clocks
// - Read lasts setup plus strobe plus hold
// - Extended read adds sixteen units per wait
// - Chip select leads read strobe by setup
// - Select-strobe mode switches select with strobe
// - Chip select held read-hold after strobe
// - Word address spans read setup through hold
// - Bank address spans read setup through hold
// - Read strobe width includes wait extension
// - Read strobe rises four units after release
// - Read data captured at strobe rising edge
// - Write lasts phases plus wait extension
// - Chip select leads write strobe by setup
// - Addresses span write setup through hold
// - Write data spans setup through hold
// - Write strobe width includes wait extension
// - Write strobe rises four units after release
// - Counts come from per-select configuration
//
// Purpose: Sequences asynchronous SRAM and flash read and write cycles.
// Assumes: Phase counts are at least one unit; MEM_WAIT_IN is an asynchronous pin.
// Notes:   A wait that stays asserted past the maximum-wait budget is abandoned.
`timescale 1ns/1ps
module async_mem_sequencer #(
    parameter int CS_N = async_mem_pkg::CS_COUNT
) (
    // Clock and reset
    input  wire logic                                        CLOCK,
    input  wire logic                                        RESETN,
    // Configuration
    input  wire logic                                        HALF_RATE,
    input  wire async_mem_pkg::cs_cfg_t [CS_N-1:0]           CS_CFG,
    // Request and answer
    input  wire logic                                        REQ_VALID,
    input  wire async_mem_pkg::access_req_t                  REQ,
    output logic                                             REQ_READY,
    output logic                                             RDATA_VALID,
    output logic [async_mem_pkg::DATA_W-1:0]                 RDATA,
    output logic                                             WAIT_TIMEOUT,
    // Memory pins
    input  wire logic                                        MEM_WAIT_IN,
    input  wire logic [async_mem_pkg::DATA_W-1:0]            MEM_DATA_IN,
    output logic [async_mem_pkg::DATA_W-1:0]                 MEM_DATA_OUT,
    output logic                                             MEM_DATA_OE,
    output logic [CS_N-1:0]                                  CHIP_SELECT_N,
    output logic                                             READ_STROBE_N,
    output logic                                             WRITE_STROBE_N,
    output logic [async_mem_pkg::WORD_ADDR_W-1:0]            WORD_ADDR,
    output logic [async_mem_pkg::BANK_ADDR_W-1:0]            BANK_BYTE_ADDR
);
    if (CS_N != async_mem_pkg::CS_COUNT) begin : g_cs_n_check
        $error("CS_N must equal the chip-select count.");
    end

    // ==========================================================
    // State encoding
    // ==========================================================
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD   = 5'h08,
        ST_TURN   = 5'h10
    } state_t;

    // ==========================================================
    // Wait input synchroniser and time unit
    // ==========================================================
    logic wait_meta_reg;
    logic wait_sync_reg;
    logic unit_tick;
    logic tick_restart;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            wait_meta_reg <= 1'b0;
            wait_sync_reg <= 1'b0;
        end else begin
            wait_meta_reg <= MEM_WAIT_IN;
            wait_sync_reg <= wait_meta_reg;
        end
    end

    time_unit_gen u_time_unit_gen (
        .CLOCK     (CLOCK),
        .RESETN    (RESETN),
        .half_rate (HALF_RATE),
        .restart   (tick_restart),
        .unit_tick (unit_tick)
    );

    // ==========================================================
    // Sequencer state
    // ==========================================================
    state_t                                       state_reg, state_next;
    async_mem_pkg::access_req_t                   acc_reg, acc_next;
    async_mem_pkg::cs_cfg_t                       cfg_reg, cfg_next;
    logic [async_mem_pkg::PHASE_W-1:0]            cnt_reg, cnt_next;
    logic [async_mem_pkg::WAIT_UNITS_W-1:0]       ext_reg, ext_next;
    logic [async_mem_pkg::PHASE_W-1:0]            ewc_reg, ewc_next;
    logic                                         waited_reg, waited_next;
    logic [CS_N-1:0]                              cs_n_reg, cs_n_next;
    logic                                         rd_n_reg, rd_n_next;
    logic                                         wr_n_reg, wr_n_next;
    logic                                         doe_reg, doe_next;
    logic                                         rvalid_reg, rvalid_next;
    logic [async_mem_pkg::DATA_W-1:0]             rdata_reg, rdata_next;
    logic                                         tmo_reg, tmo_next;
    logic                                         ready_reg, ready_next;

    async_mem_pkg::phase_cfg_t ph;
    logic [CS_N-1:0]           cs_onehot;

    assign tick_restart = (state_reg == ST_IDLE);

    always_comb begin
        state_next  = state_reg;
        acc_next    = acc_reg;
        cfg_next    = cfg_reg;
        cnt_next    = cnt_reg;
        ext_next    = ext_reg;
        ewc_next    = ewc_reg;
        waited_next = waited_reg;
        cs_n_next   = cs_n_reg;
        rd_n_next   = rd_n_reg;
        wr_n_next   = wr_n_reg;
        doe_next    = doe_reg;
        rvalid_next = 1'b0;
        rdata_next  = rdata_reg;
        tmo_next    = 1'b0;
        ready_next  = ready_reg;
        ph          = acc_reg.write ? cfg_reg.wr : cfg_reg.rd;
        cs_onehot   = '0;
        cs_onehot[acc_reg.cs] = 1'b1;
        case (state_reg)
            ST_IDLE: begin
                cs_n_next = '1;
                rd_n_next = 1'b1;
                wr_n_next = 1'b1;
                doe_next  = 1'b0;
                if (REQ_VALID && ready_reg) begin
                    acc_next    = REQ;
                    cfg_next    = CS_CFG[REQ.cs];
                    ready_next  = 1'b0;
                    ext_next    = '0;
                    ewc_next    = '0;
                    waited_next = 1'b0;
                    state_next  = ST_SETUP;
                    cnt_next    = REQ.write ? CS_CFG[REQ.cs].wr.setup : CS_CFG[REQ.cs].rd.setup;
                    if (!CS_CFG[REQ.cs].select_strobe) begin
                        cs_n_next = '1;
                        cs_n_next[REQ.cs] = 1'b0;
                    end
                    doe_next = REQ.write;
                end
            end
            ST_SETUP: begin
                if (unit_tick) begin
                    if (cnt_reg <= 8'h01) begin
                        state_next = ST_STROBE;
                        cnt_next   = ph.strobe;
                        cs_n_next  = ~cs_onehot;
                        rd_n_next  = acc_reg.write;
                        wr_n_next  = !acc_reg.write;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
            end
            ST_STROBE: begin
                if (unit_tick) begin
                    if (cfg_reg.extended_wait_enable && wait_sync_reg && !waited_reg
                        && cnt_reg <= 8'h04 && ext_reg == '0) begin
                        waited_next = 1'b1;
                        ext_next = 12'(async_mem_pkg::UNITS_PER_WAIT);
                        ewc_next = 8'h01;
                    end
                    if (ext_reg != '0) begin
                        if (!wait_sync_reg && ext_reg > 12'(async_mem_pkg::WAIT_RELEASE_UNITS)) begin
                            // The strobe must rise a fixed time after release, so the rest of the
                            // programmed strobe is dropped and only the release units remain.
                            ext_next = 12'(async_mem_pkg::WAIT_RELEASE_UNITS - 1);
                            cnt_next = 8'h01;
                        end else if (ext_reg == 12'h001 && wait_sync_reg) begin
                            if (ewc_reg >= cfg_reg.max_wait) begin
                                tmo_next = 1'b1;
                                ext_next = '0;
                                cnt_next = 8'h01;
                            end else begin
                                ext_next = 12'(async_mem_pkg::UNITS_PER_WAIT);
                                ewc_next = ewc_reg + 8'h01;
                            end
                        end else begin
                            ext_next = ext_reg - 12'h001;
                        end
                    end else if (cnt_reg > 8'h01) begin
                        cnt_next = cnt_reg - 8'h01;
                    end else if (!(cfg_reg.extended_wait_enable && wait_sync_reg && !waited_reg)) begin
                        state_next = ST_HOLD;
                        cnt_next   = ph.hold;
                        rd_n_next  = 1'b1;
                        wr_n_next  = 1'b1;
                        if (!acc_reg.write) begin
                            rdata_next  = MEM_DATA_IN;
                            rvalid_next = 1'b1;
                        end
                        if (cfg_reg.select_strobe) begin
                            cs_n_next = '1;
                        end
                    end
                end
            end
            ST_HOLD: begin
                if (unit_tick) begin
                    if (cnt_reg <= 8'h01) begin
                        state_next = ST_TURN;
                        cnt_next   = cfg_reg.turnaround;
                        cs_n_next  = '1;
                        doe_next   = 1'b0;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
            end
            ST_TURN: begin
                if (unit_tick) begin
                    if (cnt_reg <= 8'h01) begin
                        state_next = ST_IDLE;
                        ready_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - 8'h01;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg  <= ST_IDLE;
            acc_reg    <= '0;
            cfg_reg    <= '0;
            cnt_reg    <= '0;
            ext_reg    <= '0;
            ewc_reg    <= '0;
            waited_reg <= 1'b0;
            cs_n_reg   <= '1;
            rd_n_reg   <= 1'b1;
            wr_n_reg   <= 1'b1;
            doe_reg    <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            tmo_reg    <= 1'b0;
            ready_reg  <= 1'b1;
        end else begin
            state_reg  <= state_next;
            acc_reg    <= acc_next;
            cfg_reg    <= cfg_next;
            cnt_reg    <= cnt_next;
            ext_reg    <= ext_next;
            ewc_reg    <= ewc_next;
            waited_reg <= waited_next;
            cs_n_reg   <= cs_n_next;
            rd_n_reg   <= rd_n_next;
            wr_n_reg   <= wr_n_next;
            doe_reg    <= doe_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            tmo_reg    <= tmo_next;
            ready_reg  <= ready_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Address and data registers load at request and stay until the next one.
    assign WORD_ADDR      = acc_reg.word_addr;
    assign BANK_BYTE_ADDR = acc_reg.bank_byte_addr;
    assign MEM_DATA_OUT   = acc_reg.wdata;
    assign MEM_DATA_OE    = doe_reg;
    assign CHIP_SELECT_N  = cs_n_reg;
    assign READ_STROBE_N  = rd_n_reg;
    assign WRITE_STROBE_N = wr_n_reg;
    assign REQ_READY      = ready_reg;
    assign RDATA_VALID    = rvalid_reg;
    assign RDATA          = rdata_reg;
    assign WAIT_TIMEOUT   = tmo_reg;

endmodule : async_mem_sequencer

// [src/async_mem_pkg.sv]
// Purpose: Shared constants and carrier types for the asynchronous memory cycle sequencer.
// Assumes: One 25 MHz clock; phase counts arrive as plain configuration ports.
// Notes:   Time unit E is one clock at full rate or two clocks at half rate.
package async_mem_pkg;

    // ==========================================================
    // Widths and timing constants
    // ==========================================================
    localparam int WORD_ADDR_W      = 21;
    localparam int BANK_ADDR_W      = 2;
    localparam int DATA_W           = 16;
    localparam int CS_COUNT         = 4;
    localparam int CS_SEL_W         = 2;
    localparam int PHASE_W          = 8;
    localparam int WAIT_UNITS_W     = 12;
    localparam int UNITS_PER_WAIT   = 16;
    localparam int WAIT_RELEASE_UNITS = 4;
    localparam int HALF_RATE_DIV    = 2;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic [PHASE_W-1:0] setup;
        logic [PHASE_W-1:0] strobe;
        logic [PHASE_W-1:0] hold;
    } phase_cfg_t;

    typedef struct packed {
        phase_cfg_t         rd;
        phase_cfg_t         wr;
        logic [PHASE_W-1:0] turnaround;
        logic [PHASE_W-1:0] max_wait;
        logic               select_strobe;
        logic               extended_wait_enable;
    } cs_cfg_t;

    typedef struct packed {
        logic                   write;
        logic [CS_SEL_W-1:0]    cs;
        logic [WORD_ADDR_W-1:0] word_addr;
        logic [BANK_ADDR_W-1:0] bank_byte_addr;
        logic [DATA_W-1:0]      wdata;
    } access_req_t;

endpackage : async_mem_pkg

// [src/time_unit_gen.sv]
// Purpose: Produces the one-cycle enable that marks each time unit E.
// Assumes: half_rate comes from logic on the same clock.
// Notes:   The divider restarts when restart is high so a unit begins cleanly.
`timescale 1ns/1ps
module time_unit_gen (
    // Clock and reset
    input  wire logic CLOCK,
    input  wire logic RESETN,
    // Control
    input  wire logic half_rate,
    input  wire logic restart,
    // Output
    output logic      unit_tick
);
    // ==========================================================
    // Divider
    // ==========================================================
    logic div_reg;
    logic div_next;

    always_comb begin
        if (restart || !half_rate) begin
            div_next = 1'b0;
        end else begin
            div_next = ~div_reg;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            div_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign unit_tick = !half_rate || div_reg;

endmodule : time_unit_gen

// [verification/async_mem_checker.sv]
// Purpose: Concurrent checks on the sequencer's memory pins and answers.
// Assumes: Sees only the ports of the sequencer.
// Notes:   Phase widths depend on the latched setup, so the bench measures them.
`timescale 1ns/1ps
module async_mem_checker #(
    parameter int CS_N = 4
) (
    // Clock and reset
    input wire logic                   CLOCK,
    input wire logic                   RESETN,
    // Request and answer
    input wire logic                   REQ_VALID,
    input wire logic                   REQ_READY,
    input wire logic                   RDATA_VALID,
    input wire logic [15:0]            RDATA,
    input wire logic                   WAIT_TIMEOUT,
    // Memory pins
    input wire logic [15:0]            MEM_DATA_IN,
    input wire logic [15:0]            MEM_DATA_OUT,
    input wire logic                   MEM_DATA_OE,
    input wire logic [CS_N-1:0]        CHIP_SELECT_N,
    input wire logic                   READ_STROBE_N,
    input wire logic                   WRITE_STROBE_N,
    input wire logic [20:0]            WORD_ADDR,
    input wire logic [1:0]             BANK_BYTE_ADDR
);
    // ==========================================================
    // Sequences
    // ==========================================================
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    sequence take_s;
        REQ_VALID && REQ_READY;
    endsequence
    sequence strobe_s;
        !READ_STROBE_N || !WRITE_STROBE_N;
    endsequence
    // ==========================================================
    // Assertions
    // ==========================================================
    ready_drop_a: assert property (take_s |=> !REQ_READY)
        else $error("ready stayed high after a take");
    setup_first_a: assert property (take_s |=> (READ_STROBE_N && WRITE_STROBE_N) ##[0:20] strobe_s)
        else $error("strobe did not follow its setup phase");
    idle_high_a: assert property (REQ_READY |-> &CHIP_SELECT_N && READ_STROBE_N && WRITE_STROBE_N)
        else $error("line active while idle");
    one_strobe_a: assert property (READ_STROBE_N || WRITE_STROBE_N)
        else $error("both strobes low");
    select_strobe_a: assert property (strobe_s |-> !(&CHIP_SELECT_N))
        else $error("strobe low without a select");
    addr_hold_a: assert property (!(&CHIP_SELECT_N) |=> $stable(WORD_ADDR) && $stable(BANK_BYTE_ADDR))
        else $error("address moved during an access");
    write_data_a: assert property (!WRITE_STROBE_N |-> MEM_DATA_OE && $stable(MEM_DATA_OUT))
        else $error("write data not held under the strobe");
    read_free_a: assert property (!READ_STROBE_N |-> !MEM_DATA_OE)
        else $error("data driven during a read");
    rdata_capture_a: assert property ($rose(READ_STROBE_N) |-> RDATA_VALID && RDATA == $past(MEM_DATA_IN))
        else $error("read data not taken at strobe rise");
    valid_cause_a: assert property (RDATA_VALID |-> $rose(READ_STROBE_N))
        else $error("read data valid without strobe rise");
    timeout_end_a: assert property (WAIT_TIMEOUT |=> !WAIT_TIMEOUT ##[0:8] (READ_STROBE_N && WRITE_STROBE_N))
        else $error("strobe kept low after a wait timeout");
endmodule : async_mem_checker

bind async_mem_sequencer async_mem_checker #(.CS_N(CS_N)) u_async_mem_checker (
    .CLOCK, .RESETN, .REQ_VALID, .REQ_READY, .RDATA_VALID, .RDATA, .WAIT_TIMEOUT, .MEM_DATA_IN,
    .MEM_DATA_OUT, .MEM_DATA_OE, .CHIP_SELECT_N, .READ_STROBE_N, .WRITE_STROBE_N, .WORD_ADDR,
    .BANK_BYTE_ADDR
);

// [verification/async_mem_partner.sv]
// Purpose: Behavioural asynchronous memory on the far side of the sequencer.
// Assumes: One word per access; the bench sets the wait length in clocks.
// Notes:   A released data bus shows the inverse of its last driven word.
`timescale 1ns/1ps
module async_mem_partner (
    // Clock
    input  wire logic        clock,
    // Memory pins
    input  wire logic [3:0]  cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    output logic [15:0]      rdata,
    output logic             wait_out,
    // Bench control
    input  wire logic [7:0]  wait_len
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [7:0]  cnt = 8'h00;
    logic        busy_d = 1'b0;
    logic        sel;
    assign sel = !(&cs_n);
    assign rdata = (sel && !rd_n) ? mem[addr] : ~last;
    initial begin
        wait_out = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h0000;
        end
    end
    always @(posedge clock) begin
        busy_d <= !rd_n || !wr_n;
        if ((!rd_n || !wr_n) && !busy_d) begin
            cnt <= wait_len;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
        wait_out <= cnt != 8'h00;
        if (sel && !rd_n) begin
            last <= mem[addr];
        end
        if (sel && !wr_n) begin
            mem[addr] <= wdata;
        end
    end
endmodule : async_mem_partner

// [verification/async_mem_sequencer_tb.sv]
// Purpose: Self-checking bench for the asynchronous memory sequencer.
// Assumes: The partner model stores writes, answers reads and drives wait.
// Notes:   Strobe and select widths are counted in clocks per access.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module async_mem_sequencer_tb;
    typedef struct {int st; int cs; bit w; logic [22:0] a;} exp_t;
    logic clock = 1'b0, resetn = 1'b0, half_rate = 1'b0, req_valid = 1'b0, hr;
    async_mem_pkg::cs_cfg_t [3:0] cfg = '0;
    async_mem_pkg::access_req_t   req = '0;
    logic rdy, rvalid, tout, mwait, moe, rd_n, wr_n, to_seen = 1'b0, cs_d = 1'b1;
    logic [15:0] rdata, mdin, mdout, exp_d;
    logic [3:0]  cs_n;
    logic [20:0] waddr;
    logic [1:0]  baddr;
    logic [7:0]  wait_len = 8'h00, wl;
    logic [31:0] seed = 32'h00014b61, r;
    exp_t eq[$], m;
    logic [15:0] rq[$];
    int errors = 0, checks_done = 0, stw = 0, csw = 0, n;
    async_mem_sequencer u_async_mem_sequencer (.CLOCK(clock), .RESETN(resetn), .HALF_RATE(half_rate),
        .CS_CFG(cfg), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(rdy), .RDATA_VALID(rvalid),
        .RDATA(rdata), .WAIT_TIMEOUT(tout), .MEM_WAIT_IN(mwait), .MEM_DATA_IN(mdin), .MEM_DATA_OUT(mdout),
        .MEM_DATA_OE(moe), .CHIP_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
        .WORD_ADDR(waddr), .BANK_BYTE_ADDR(baddr));
    async_mem_partner u_async_mem_partner (.clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(waddr[3:0]), .wdata(mdout), .rdata(mdin), .wait_out(mwait), .wait_len(wait_len));
    always #20 clock = ~clock;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // ==========================================================
    // One access: note the expected widths, then request
    // ==========================================================
    task automatic go(input logic wr, input logic [1:0] c, input logic [31:0] v, input logic [7:0] w);
        async_mem_pkg::phase_cfg_t ph;
        exp_t e;
        int u;
        int k;
        k = 0;
        @(negedge clock);
        while (rdy !== 1'b1 && k < 2000) begin
            @(negedge clock);
            k++;
        end
        if (k >= 2000) errors++;
        half_rate = hr;
        u = hr ? 2 : 1;
        ph = wr ? cfg[c].wr : cfg[c].rd;
        e.st = ph.strobe * u;
        e.cs = cfg[c].select_strobe ? e.st : (ph.setup + ph.strobe + ph.hold) * u;
        e.w = cfg[c].extended_wait_enable && w != 8'h00;
        e.a = {v[31:11], v[6:5]};
        eq.push_back(e);
        if (!wr) rq.push_back(v[27:12]);
        wait_len = w;
        req = '{wr, c, v[31:11], v[6:5], v[27:12]};
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
    endtask : go
    // ==========================================================
    // Result watcher
    // ==========================================================
    always @(negedge clock) begin
        if (!(&cs_n)) begin
            if (cs_d) begin
                csw = 0;
                stw = 0;
            end
            csw++;
            if (!rd_n || !wr_n) stw++;
        end else if (!cs_d && eq.size() > 0) begin
            m = eq.pop_front();
            `CHK({waddr, baddr}, m.a)
            if (m.w) begin
                `CHK(stw > m.st, 1'b1)
            end else begin
                `CHK(stw, m.st)
                `CHK(csw, m.cs)
            end
        end
        cs_d = &cs_n;
        if (rvalid === 1'b1) begin
            exp_d = rq.size() > 0 ? rq.pop_front() : 16'hxxxx;
            `CHK(rdata, exp_d)
        end
        if (tout === 1'b1) to_seen = 1'b1;
    end
    initial begin
        #(40 * 10000);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        for (int i = 0; i < 24; i++) begin
            r = xs();
            cfg[i[1:0]].rd = '{8'(r[1:0]) + 8'h01, 8'(r[3:2]) + 8'h06, 8'(r[5:4]) + 8'h01};
            cfg[i[1:0]].wr = cfg[i[1:0]].rd;
            cfg[i[1:0]].turnaround = 8'(r[7:6]) + 8'h01;
            cfg[i[1:0]].max_wait = 8'h04;
            cfg[i[1:0]].select_strobe = r[8];
            cfg[i[1:0]].extended_wait_enable = r[9];
            hr = r[10];
            wl = (i % 3 == 0) ? 8'(cfg[i[1:0]].rd.strobe * (r[10] ? 2 : 1)) : 8'h00;
            r = xs();
            go(1'b1, i[1:0], r, wl);
            go(1'b0, i[1:0], r, wl);
            $display("test access pair %0d done", i);
        end
        cfg[0].max_wait = 8'h01;
        cfg[0].extended_wait_enable = 1'b1;
        hr = 1'b0;
        go(1'b1, 2'h0, xs(), 8'd100);
        n = 0;
        while ((eq.size() > 0 || rq.size() > 0 || rdy !== 1'b1) && n < 4000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 4000) errors++;
        `CHK(to_seen, 1'b1)
        $display("test wait timeout done");
        print_verdict();
    end
endmodule : async_mem_sequencer_tb
